// file: pbc_defs.svh
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define PBC_BMC_OFF      12'h000
`define PBC_BIT_SPEED    13
`define PBC_BIT_AN_EN    12
`define PBC_BIT_PWRDN    11
`define PBC_BIT_ISO      10
`define PBC_BIT_RESTART  9
`define PBC_BIT_DUPLEX   8
`define PBC_BIT_COLTEST  7
`define PBC_RSVD_MSB     6

// ****************************************
// Reset values
// ****************************************
`define PBC_RST_SPEED    1'b0
`define PBC_RST_AN_EN    1'b0
`define PBC_RST_PWRDN    1'b0
`define PBC_RST_ISO      1'b0
`define PBC_RST_RESTART  1'b0
`define PBC_RST_DUPLEX   1'b0
`define PBC_RST_COLTEST  1'b0
`define PBC_STRAP_WAIT   2'h2

// ****************************************
// Timing
// ****************************************
`define PBC_PCLK_NS      40
`define PBC_BIT_NS_100M  10
`define PBC_COL_ON_NS    (512 * `PBC_BIT_NS_100M)
`define PBC_COL_OFF_NS   (4 * `PBC_BIT_NS_100M)
`define PBC_COL_ON_CYC   (`PBC_COL_ON_NS / `PBC_PCLK_NS)
`define PBC_COL_OFF_CYC  (`PBC_COL_OFF_NS / `PBC_PCLK_NS)

`endif

// file: pbc_pkg.sv
package pbc_pkg;

    // Receive side of the MAC data interface
    typedef struct packed
    {
        logic       dv;
        logic       col;
        logic [3:0] d;
    } pbc_mii_rx_type;

    // Whole state of the control block
    typedef struct packed
    {
        logic           speed;
        logic           an_en;
        logic           pwrdn;
        logic           iso;
        logic           restart;
        logic           duplex;
        logic           coltest;
        logic [1:0]     an_sync;
        logic [1:0]     dup_sync;
        logic [1:0]     strap_cnt;
        logic           strap_done;
        logic           restart_pulse;
        logic           col;
        logic [31:0]    rdata;
        pbc_mii_rx_type rx;
    } pbc_state_type;

endpackage

// file: pbc_ctrl.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_ctrl
    import pbc_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           strap_an_en,
    input  wire logic           strap_duplex,
    input  wire logic           an_started,
    input  wire logic           an_speed_100,
    input  wire logic           an_full_duplex,
    output logic                an_restart,
    input  wire logic           mii_tx_en,
    output logic                core_tx_en,
    input  wire pbc_mii_rx_type core_rx,
    output pbc_mii_rx_type      mii_rx,
    output logic                mii_rx_oe,
    output logic                mii_col,
    output logic                mii_col_oe,
    output logic                power_down,
    output logic                speed_100,
    output logic                full_duplex
);

    // ****************************************
    // Bus decode
    // ****************************************

    pbc_state_type s_q;        // Registered state
    pbc_state_type s_d;        // Next state
    logic          hit;        // Address selects the register
    logic          wr;         // Write takes effect this edge
    logic          setup;      // Setup phase of any transfer
    logic          live;       // Transceiver functions running
    logic          set_rst;    // Accepted restart request
    logic [15:0]   reg_view;   // Register as software sees it

    // Zero wait states: every access ends in one cycle
    assign pready  = 1'b1;
    assign hit     = (paddr == `PBC_BMC_OFF);
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & hit;
    // Unmapped addresses answer with an error
    assign pslverr = psel & penable & ~hit;
    assign prdata  = s_q.rdata;

    always_comb
    begin
        reg_view = 16'h0000;
        reg_view[`PBC_BIT_SPEED]   = s_q.speed;
        reg_view[`PBC_BIT_AN_EN]   = s_q.an_en;
        reg_view[`PBC_BIT_PWRDN]   = s_q.pwrdn;
        reg_view[`PBC_BIT_ISO]     = s_q.iso;
        reg_view[`PBC_BIT_RESTART] = s_q.restart;
        reg_view[`PBC_BIT_DUPLEX]  = s_q.duplex;
        reg_view[`PBC_BIT_COLTEST] = s_q.coltest;
    end

    // ****************************************
    // Next-state logic
    // ****************************************

    // All state updates in one place
    always_comb
    begin
        s_d = s_q;
        set_rst = 1'b0;
        // Strap pins pass two flops before use
        s_d.an_sync  = {s_q.an_sync[0], strap_an_en};
        s_d.dup_sync = {s_q.dup_sync[0], strap_duplex};
        // Read data is captured in the setup phase
        if (setup)
        begin
            s_d.rdata = hit ? {16'h0000, reg_view} : 32'h0000_0000;
        end
        // Upper byte holds every writable bit except collision test
        if (wr && pstrb[1])
        begin
            s_d.speed  = pwdata[`PBC_BIT_SPEED];
            s_d.an_en  = pwdata[`PBC_BIT_AN_EN];
            s_d.pwrdn  = pwdata[`PBC_BIT_PWRDN];
            s_d.iso    = pwdata[`PBC_BIT_ISO];
            s_d.duplex = pwdata[`PBC_BIT_DUPLEX];
        end
        // Lower byte: only collision test is writable
        if (wr && pstrb[0])
        begin
            s_d.coltest = pwdata[`PBC_BIT_COLTEST];
        end
        // software clear only drops the flag
        if (wr && pstrb[1] && !pwdata[`PBC_BIT_RESTART])
        begin
            s_d.restart = 1'b0;
        end
        if (an_started)
        begin
            s_d.restart = 1'b0;
        end
        set_rst = wr && pstrb[1] && pwdata[`PBC_BIT_RESTART] && s_d.an_en;
        // a new request wins over any clear
        if (set_rst)
        begin
            s_d.restart = 1'b1;
        end
        s_d.restart_pulse = set_rst;
        // Straps load once the synchroniser has settled
        if (!s_q.strap_done)
        begin
            s_d.strap_cnt = s_q.strap_cnt + 2'h1;
            if (s_q.strap_cnt == `PBC_STRAP_WAIT)
            begin
                s_d.an_en      = s_q.an_sync[1];
                s_d.duplex     = s_q.dup_sync[1];
                s_d.strap_done = 1'b1;
            end
        end
        // and drops with it one cycle later
        // Next liveness used so pins go quiet on the isolating edge
        if (s_d.pwrdn || s_d.iso)
        begin
            s_d.col = 1'b0;
        end
        else if (s_q.coltest)
        begin
            s_d.col = mii_tx_en;
        end
        else
        begin
            s_d.col = core_rx.col;
        end
        // receive data is held low while detached
        s_d.rx = (s_d.pwrdn || s_d.iso) ? '0 : core_rx;
    end

    // ****************************************
    // State register
    // ****************************************

    // Reset takes constants only; straps load later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.speed   <= `PBC_RST_SPEED;
            s_q.an_en   <= `PBC_RST_AN_EN;
            s_q.pwrdn   <= `PBC_RST_PWRDN;
            s_q.iso     <= `PBC_RST_ISO;
            s_q.restart <= `PBC_RST_RESTART;
            s_q.duplex  <= `PBC_RST_DUPLEX;
            s_q.coltest <= `PBC_RST_COLTEST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // power down or isolate stops the port
    assign live        = ~s_q.pwrdn & ~s_q.iso;
    assign power_down  = s_q.pwrdn;
    assign an_restart  = s_q.restart_pulse;
    assign mii_rx_oe   = live;
    assign mii_col_oe  = live;
    assign mii_col     = s_q.col;
    assign mii_rx      = s_q.rx;
    // transmit from the MAC is ignored while the port is stopped
    assign core_tx_en  = live & mii_tx_en;
    // manual duplex when negotiation is off
    assign speed_100   = s_q.an_en ? an_speed_100 : s_q.speed;
    assign full_duplex = s_q.an_en ? an_full_duplex : s_q.duplex;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Accepted write of one to restart
    sequence rst_req_s;
        wr && pstrb[1] && pwdata[`PBC_BIT_RESTART] && s_d.an_en;
    endsequence

    // Pending restart with no start and no clear
    sequence rst_wait_s;
        s_q.restart && !an_started && !(wr && pstrb[1]);
    endsequence

    pwr_stops_port_a: assert property
        (power_down |-> !mii_rx_oe && !mii_col_oe && !core_tx_en && !mii_col)
        else $error("port active during power down");

    iso_detach_a: assert property
        (wr && pstrb[1] && pwdata[`PBC_BIT_ISO] |=> !mii_rx_oe && !mii_col_oe)
        else $error("isolate did not release pins");

    restart_pulse_a: assert property
        (rst_req_s |=> an_restart && s_q.restart ##1 !an_restart)
        else $error("restart not issued as one pulse");

    restart_ignore_a: assert property
        (wr && pstrb[1] && !s_d.an_en |=> !an_restart && (!s_q.restart || $past(s_q.restart)))
        else $error("restart taken while disabled");

    restart_hold_a: assert property
        (rst_wait_s |=> s_q.restart)
        else $error("restart bit cleared too early");

    restart_clear_a: assert property
        (s_q.restart && an_started && !set_rst |=> !s_q.restart)
        else $error("restart bit not self-cleared");

    sw_clear_a: assert property
        (wr && pstrb[1] && !pwdata[`PBC_BIT_RESTART] |=> !an_restart && !s_q.restart)
        else $error("software clear disturbed restart");

    duplex_sel_a: assert property
        (!s_q.an_en |-> full_duplex == s_q.duplex)
        else $error("manual duplex not applied");

    col_raise_a: assert property
        (s_q.coltest && mii_tx_en && !s_d.pwrdn && !s_d.iso |=> mii_col)
        else $error("collision test col late");

    col_drop_a: assert property
        (s_q.coltest && !mii_tx_en |=> !mii_col)
        else $error("collision test col not dropped");

    rsvd_zero_a: assert property
        (psel && penable && !pwrite |-> prdata[`PBC_RSVD_MSB:0] == 7'h00)
        else $error("reserved bits read nonzero");

    an_override_a: assert property
        (s_q.an_en |-> speed_100 == an_speed_100 && full_duplex == an_full_duplex)
        else $error("negotiated mode not used");

    iso_ignore_tx_a: assert property
        (s_q.iso |-> !core_tx_en && !mii_rx_oe && mii_rx == '0)
        else $error("isolated port still active");

endmodule

// file: pbc_mac_model.sv
`timescale 1ns/1ps
// ****************************************
// MAC side of the data interface
// ****************************************
module pbc_mac_model
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic send,
    input  wire logic mii_col,
    input  wire logic mii_col_oe,
    output logic      mii_tx_en,
    output logic      col_seen
);
    // Released col line falls to its pull-down, never shows a stale 1
    assign col_seen = mii_col_oe ? mii_col : 1'b0;

    // Transmit enable launched just after the edge, as a real MAC does
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mii_tx_en <= 1'b0;
        else
            mii_tx_en <= send;
    end
endmodule

// file: pbc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_ctrl_tb_top;
    import pbc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0, prdata, rd;
    logic [3:0]     pstrb = 4'hf;
    logic           pready, pslverr, er, send = 1'b0;
    logic           an_started = 1'b0, an_speed_100 = 1'b0, an_full_duplex = 1'b0;
    logic           an_restart, mii_tx_en, core_tx_en, mii_rx_oe, mii_col, mii_col_oe;
    logic           power_down, speed_100, full_duplex, col_seen;
    pbc_mii_rx_type core_rx = 6'h15, mii_rx;
    int             err_count = 0, comparisons = 0, pulses = 0, n;

    // Free-running bus clock, 40 ns period
    always #20 pclk = ~pclk;

    // Straps tied: negotiation off, full duplex after reset
    pbc_ctrl u_pbc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .strap_an_en(1'b0), .strap_duplex(1'b1),
        .an_started, .an_speed_100, .an_full_duplex, .an_restart, .mii_tx_en,
        .core_tx_en, .core_rx, .mii_rx, .mii_rx_oe, .mii_col, .mii_col_oe,
        .power_down, .speed_100, .full_duplex);
    pbc_mac_model u_pbc_mac_model (.pclk, .presetn, .send, .mii_col, .mii_col_oe,
        .mii_tx_en, .col_seen);

    // Counts restart pulses mid-cycle, so the count is settled before the next rising edge
    always @(negedge pclk)
        if (an_restart === 1'b1)
            pulses++;

    // ****************************************
    // Tasks
    // ****************************************
    // One APB transfer, entered just after an edge, ends one idle edge later
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits for the answer; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %0t word %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_b(input logic g, input logic e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_0100);
        cmp_b(full_duplex, 1'b1);
        // Reserved bits dropped, restart refused with negotiation off
        apb(1'b1, 12'h000, 32'h0000_07ff);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_0580);
        cmp_w(32'(pulses), 32'h0);
        send <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp_b(core_tx_en, 1'b0);
        cmp_b(mii_rx_oe, 1'b0);
        cmp_b(col_seen, 1'b0);
        send <= 1'b0;
        // Back to normal with collision test and half duplex
        apb(1'b1, 12'h000, 32'h0000_0080);
        cmp_b(full_duplex, 1'b0);
        cmp_b(mii_rx_oe, 1'b1);
        cmp_w(32'(mii_rx), 32'h0000_0015);
        cmp_b(col_seen, 1'b0);
        send <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (col_seen !== 1'b1 && n < 130);
        cmp_b(n <= `PBC_COL_ON_CYC, 1'b1);
        cmp_b(core_tx_en, 1'b1);
        send <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 cmp_b(col_seen, 1'b0);
        @(posedge pclk);
        // Power down keeps registers alive
        apb(1'b1, 12'h000, 32'h0000_0800);
        cmp_b(power_down, 1'b1);
        cmp_b(mii_col_oe, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_0800);
        // Negotiation on: restart, override of speed and duplex
        an_full_duplex <= 1'b1;
        an_speed_100 <= 1'b1;
        apb(1'b1, 12'h000, 32'h0000_1200);
        cmp_b(full_duplex, 1'b1);
        cmp_b(speed_100, 1'b1);
        cmp_w(32'(pulses), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_1200);
        apb(1'b1, 12'h000, 32'h0000_1000);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_1000);
        cmp_w(32'(pulses), 32'h1);
        apb(1'b1, 12'h000, 32'h0000_1200);
        cmp_w(32'(pulses), 32'h2);
        an_started <= 1'b1;
        @(posedge pclk);
        an_started <= 1'b0;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_1000);
        // Unmapped word refused, register untouched
        apb(1'b1, 12'h004, 32'h0000_ffff);
        cmp_b(er, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        cmp_w(rd, 32'h0000_1000);
        complete_run();
    end

    // Whole run is well under 400 cycles; this cuts a hang short
    initial
    begin
        repeat (4000) @(posedge pclk);
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule
